// >>> port_expander.sv
// I2C port expander slave with latching transition detection
//
// Contract
// [R01] Snapshot compared with live inputs sets flags
// [R02] Address acknowledge relatches snapshot, clears flags
// [R03] Input read: data byte, then old flags
// [R04] Long reads alternate, relatch per byte pair
// [R05] Eight-bit mask gates flags onto alert
// [R06] Flags set regardless of mask
// [R07] No alert during read; deferred to STOP
// [R08] No alert at STOP if already reported
// [R09] Flags stay set until next clearing access
// [R10] Slave only; SCL input, SDA open-drain
// [R11] Master frames START, address, bytes, STOP
// [R12] Detect START and STOP on SDA edges
// [R13] One bit per SCL pulse, stable while high
// [R14] Device acknowledges every received byte; code leaves an output-group byte unacknowledged when the queue is full
// [R15] Master leaves last read byte unacknowledged
// [R16] Eighth address bit selects read or write
// [R17] Prefixes 110 inputs, 101 outputs
// [R18] Four-level pins give address bits 3..0
// [R19] Power-up outputs follow grounded address pins
// [R20] Any access clears alert and flags
// [R21] Mask resets to all ones
// [R22] Each input-group write byte replaces mask
// [R23] Address pins decoded on every transmission
// [R24] Unmasked flag outside read drives alert low
// [R25] Bus and inputs synchronised before use
`timescale 1ns/1ns
`include "expander_params.svh"

module expander_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and control
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             enable,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;

  // Pointers carry a wrap bit so full and empty are exact
  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (enable) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      if (push) begin
        mem_q[wr_q[AW-1:0]] <= in_data;
      end
    end
  end
endmodule : expander_fifo

module port_expander (
  // Clock, reset, freeze
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    enable,
  // Serial bus pins
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  // Four-level address pins
  input  wire logic                    addr_pin_high,
  input  wire logic                    addr_pin_low,
  // Ports
  input  wire expander_pkg::port_byte_t input_pins,
  output expander_pkg::port_byte_t     output_pins,
  input  wire logic                    apply_ready,
  // Alert, active low
  output logic                         alert_n
);
  import expander_pkg::*;

  // Classify a pin by what it failed to follow since START
  function automatic pin_kind_e classify(input logic miss_scl, input logic miss_sda,
                                         input logic level);
    if (!miss_sda) return PIN_SDA;
    if (!miss_scl) return PIN_SCL;
    return level ? PIN_SUPPLY : PIN_GND;
  endfunction : classify

  // Map a pin kind to its two address bits
  function automatic logic [1:0] pin_code(input pin_kind_e kind, input logic high);
    case (kind)
      PIN_SCL:    return high ? `HI_CODE_SCL : `LO_CODE_SCL;
      PIN_SDA:    return high ? `HI_CODE_SDA : `LO_CODE_SDA;
      PIN_GND:    return high ? `HI_CODE_GND : `LO_CODE_GND;
      default:    return high ? `HI_CODE_SUPPLY : `LO_CODE_SUPPLY;
    endcase
  endfunction : pin_code

  // Two-stage synchronisers; stage one feeds only stage two
  logic [11:0] meta_q, sync_q;
  logic        scl_p_q, sda_p_q;
  logic        scl_s, sda_s, hi_s, lo_s;
  port_byte_t  in_s;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // Bus and strap bits idle high; input bits match the cleared snapshot
      meta_q  <= 12'hf00;
      sync_q  <= 12'hf00;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (enable) begin
      meta_q  <= {scl_in, sda_in, addr_pin_high, addr_pin_low, input_pins};
      sync_q  <= meta_q; // see [R25]
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign {scl_s, sda_s, hi_s, lo_s, in_s} = sync_q;

  // Bus events, all seen on synchronised levels
  logic rise, fall, start_ev, stop_ev;
  assign rise     = scl_s && !scl_p_q;
  assign fall     = !scl_s && scl_p_q;
  assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s; // see [R12]
  assign stop_ev  = scl_s && scl_p_q && !sda_p_q && sda_s; // see [R12]

  // Bus engine state
  bus_state_e state_q, state_d;
  logic [3:0] bit_q, bit_d, miss_q, miss_d;
  port_byte_t shift_q, shift_d, mask_q, mask_d, snap_q, snap_d;
  port_byte_t flags_q, flags_d, saved_q, saved_d, out_q, out_d;
  logic       oe_q, oe_d, grp_out_q, grp_out_d, rw_q, rw_d, odd_q, odd_d;
  logic       acked_q, acked_d, in_read_q, in_read_d, alert_q, alert_d;
  logic [1:0] strap_q, strap_d;
  logic       relatch, mask_we, push, fifo_in_ready, fifo_valid, pop;
  logic [3:0] my_low;
  port_byte_t fifo_data, tx_byte;
  logic [6:0] addr;

  assign my_low  = {pin_code(classify(miss_d[3], miss_d[2], hi_s), 1'b1),
                    pin_code(classify(miss_d[1], miss_d[0], lo_s), 1'b0)};
  assign addr    = shift_q[7:1];
  assign tx_byte = grp_out_q ? out_q : (odd_q ? saved_q : snap_q); // see [R03]

  // Next-state logic of the serial engine
  always_comb begin
    state_d   = state_q;
    bit_d     = bit_q;
    miss_d    = miss_q;
    shift_d   = shift_q;
    oe_d      = oe_q;
    grp_out_d = grp_out_q;
    rw_d      = rw_q;
    odd_d     = odd_q;
    acked_d   = acked_q;
    in_read_d = in_read_q;
    relatch   = 1'b0;
    mask_we   = 1'b0;
    push      = 1'b0;
    if (start_ev) begin
      state_d = ST_ADDR;
      bit_d   = 4'h0;
      miss_d  = 4'h0; // see [R23]
      oe_d    = 1'b0;
    end else if (stop_ev) begin
      state_d   = ST_IDLE;
      oe_d      = 1'b0;
      in_read_d = 1'b0; // see [R07]
    end else begin
      case (state_q)
        ST_ADDR: begin
          miss_d = miss_q | {hi_s != scl_s, hi_s != sda_s, lo_s != scl_s, lo_s != sda_s};
          if (rise) begin
            shift_d = {shift_q[6:0], sda_s}; // see [R13]
            bit_d   = bit_q + 4'h1;
          end
          if (fall && bit_q == `BYTE_DONE) begin
            state_d = ST_IDLE;
            if (addr[3:0] == my_low &&
                (addr[6:4] == `IN_GROUP_PREFIX || addr[6:4] == `OUT_GROUP_PREFIX)) begin
              state_d   = ST_ADDR_ACK; // see [R17] [R18]
              oe_d      = 1'b1;        // see [R14]
              grp_out_d = addr[6:4] == `OUT_GROUP_PREFIX;
              rw_d      = shift_q[0]; // see [R16]
              odd_d     = 1'b0;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (rise) begin
            relatch   = 1'b1;   // see [R02] [R20]
            in_read_d = rw_q;
          end
          if (fall) begin
            bit_d   = 4'h0;
            state_d = rw_q ? ST_READ : ST_WRITE;
            shift_d = tx_byte;
            oe_d    = rw_q && !tx_byte[7];
          end
        end
        ST_READ: begin
          if (fall) begin
            bit_d = bit_q + 4'h1;
            if (bit_q == `LAST_TX_BIT) begin
              oe_d    = 1'b0;
              odd_d   = !odd_q;
              state_d = ST_READ_ACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d    = !shift_q[6];
            end
          end
        end
        ST_READ_ACK: begin
          if (rise) begin
            acked_d = !sda_s; // see [R15]
            relatch = !sda_s && !odd_q && !grp_out_q; // see [R04]
          end
          if (fall) begin
            bit_d   = 4'h0;
            state_d = acked_q ? ST_READ : ST_IDLE;
            shift_d = tx_byte;
            oe_d    = acked_q && !tx_byte[7];
          end
        end
        ST_WRITE: begin
          if (rise) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_d   = bit_q + 4'h1;
          end
          if (fall && bit_q == `BYTE_DONE) begin
            state_d = ST_WRITE_ACK;
            mask_we = !grp_out_q; // see [R22]
            push    = grp_out_q && fifo_in_ready;
            oe_d    = !grp_out_q || fifo_in_ready; // see [R14]
          end
        end
        ST_WRITE_ACK: begin
          if (fall) begin
            oe_d    = 1'b0;
            bit_d   = 4'h0;
            state_d = ST_WRITE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // Next values of ports, flags, mask and alert
  always_comb begin
    snap_d  = snap_q;
    saved_d = saved_q;
    flags_d = flags_q | (in_s ^ snap_q); // see [R01] [R06] [R09]
    mask_d  = mask_we ? shift_q : mask_q; // see [R05]
    alert_d = alert_q;
    out_d   = pop ? fifo_data : out_q;
    strap_d = strap_q;
    if (relatch) begin
      snap_d  = in_s;     // see [R02]
      saved_d = flags_q;
      flags_d = 8'h00;
      alert_d = 1'b1;     // see [R20]
    end else if (!in_read_q && |(flags_q & mask_q)) begin
      alert_d = 1'b0;     // see [R24] [R07] [R08]
    end
    if (strap_q != `STRAP_DONE) begin
      strap_d = strap_q + 2'h1;
      if (strap_q == `STRAP_LOAD) begin
        out_d = {{4{hi_s}}, {4{lo_s}}}; // see [R19]
      end
    end
  end

  // Registers, frozen while enable is low
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q   <= ST_IDLE;
      bit_q     <= 4'h0;
      miss_q    <= 4'h0;
      shift_q   <= 8'h00;
      oe_q      <= 1'b0;
      grp_out_q <= 1'b0;
      rw_q      <= 1'b0;
      odd_q     <= 1'b0;
      acked_q   <= 1'b0;
      in_read_q <= 1'b0;
      snap_q    <= 8'h00;
      saved_q   <= 8'h00;
      flags_q   <= 8'h00;
      mask_q    <= `MASK_RESET; // see [R21]
      alert_q   <= 1'b1;
      out_q     <= 8'h00;
      strap_q   <= 2'h0;
    end else if (enable) begin
      state_q   <= state_d;
      bit_q     <= bit_d;
      miss_q    <= miss_d;
      shift_q   <= shift_d;
      oe_q      <= oe_d;
      grp_out_q <= grp_out_d;
      rw_q      <= rw_d;
      odd_q     <= odd_d;
      acked_q   <= acked_d;
      in_read_q <= in_read_d;
      snap_q    <= snap_d;
      saved_q   <= saved_d;
      flags_q   <= flags_d;
      mask_q    <= mask_d;
      alert_q   <= alert_d;
      out_q     <= out_d;
      strap_q   <= strap_d;
    end
  end

  // Up to 32 output bytes queue here for a slow consumer; a byte arriving while the queue is full is dropped unacknowledged
  expander_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .enable    (enable),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_q),
    .out_valid (fifo_valid),
    .out_ready (apply_ready && strap_q == `STRAP_DONE),
    .out_data  (fifo_data)
  );
  assign pop = fifo_valid && apply_ready && strap_q == `STRAP_DONE;

  // Open-drain: only ever pulls low, never drives SCL
  assign sda_out     = 1'b0; // see [R10]
  assign sda_oe      = oe_q;
  assign output_pins = out_q;
  assign alert_n     = alert_q;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n || !enable);

  alert_read_hold_a: assert property (in_read_q && alert_q |=> alert_q) // see [R07]
    else $error("alert asserted during read");
  relatch_clear_a: assert property (relatch |=> flags_q == 8'h00 && snap_q == $past(in_s)) // see [R02]
    else $error("relatch did not clear flags or load snapshot");
  flag_sticky_a: assert property (!relatch |=> (flags_q & $past(flags_q)) == $past(flags_q)) // see [R09]
    else $error("transition flag dropped");
  flag_set_a: assert property (!relatch && (in_s != snap_q) |=> // see [R06]
      (flags_q & $past(in_s ^ snap_q)) == $past(in_s ^ snap_q))
    else $error("change did not set flag");
  mask_write_a: assert property (mask_we |=> mask_q == $past(shift_q)) // see [R22]
    else $error("mask not written");
  alert_fire_a: assert property (!in_read_q && !relatch && |(flags_q & mask_q) |=> !alert_q) // see [R24]
    else $error("alert missing");
  addr_ack_a: assert property (state_q == ST_ADDR_ACK |-> oe_q) // see [R14]
    else $error("address not acknowledged");
  stop_idle_a: assert property (stop_ev |=> state_q == ST_IDLE && !oe_q && !in_read_q) // see [R12]
    else $error("stop not honoured");
  read_pair_c: cover property (state_q == ST_READ_ACK && relatch);
  mask_write_c: cover property (mask_we);
  alert_low_c: cover property ($fell(alert_q));
  fifo_full_c: cover property (!fifo_in_ready);
endmodule : port_expander

// >>> expander_params.svh
// Constants for the transition-detecting port expander
`ifndef EXPANDER_PARAMS_SVH
`define EXPANDER_PARAMS_SVH
// Upper three slave address bits per group
`define IN_GROUP_PREFIX  3'h6
`define OUT_GROUP_PREFIX 3'h5
// Power-up interrupt mask
`define MASK_RESET       8'hff
// High address pin codes (address bits 3..2)
`define HI_CODE_SCL      2'h0
`define HI_CODE_SDA      2'h1
`define HI_CODE_GND      2'h2
`define HI_CODE_SUPPLY   2'h3
// Low address pin codes (address bits 1..0)
`define LO_CODE_GND      2'h0
`define LO_CODE_SUPPLY   2'h1
`define LO_CODE_SCL      2'h2
`define LO_CODE_SDA      2'h3
// Bit counter value after a whole byte, and at the last sent bit
`define BYTE_DONE        4'h8
`define LAST_TX_BIT      4'h7
// Power-up strap capture: load at count 2, settled at 3
`define STRAP_LOAD       2'h2
`define STRAP_DONE       2'h3
// Write-path FIFO shape
`define FIFO_WIDTH       8
`define FIFO_DEPTH       32
`endif

// >>> expander_pkg.sv
// Types for the transition-detecting port expander
package expander_pkg;
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_ADDR      = 3'h1,
    ST_ADDR_ACK  = 3'h2,
    ST_WRITE     = 3'h3,
    ST_WRITE_ACK = 3'h4,
    ST_READ      = 3'h5,
    ST_READ_ACK  = 3'h6
  } bus_state_e;
  typedef enum logic [1:0] {
    PIN_GND    = 2'h0,
    PIN_SUPPLY = 2'h1,
    PIN_SCL    = 2'h2,
    PIN_SDA    = 2'h3
  } pin_kind_e;
  typedef logic [7:0] port_byte_t;
endpackage : expander_pkg

// >>> i2c_master_model.sv
// Behavioural bus master that drives the expander's clock and data pins
`timescale 1ns/1ns
module i2c_master_model (
  // System clock paces the bus
  input  wire logic clock,
  // Bus wires
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drive
);
  // Bus idles released, clock high
  initial begin
    scl       = 1'b1;
    sda_drive = 1'b0;
  end

  // Ten clocks per half of the 80 ns bus period
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // Data falls while clock is high
  task automatic start();
    tick(3);
    sda_drive <= 1'b1;
    tick(10);
    scl <= 1'b0;
  endtask : start

  // Data rises while clock is high, then the clock stays high
  task automatic stop();
    tick(3);
    sda_drive <= 1'b1;
    tick(7);
    scl <= 1'b1;
    tick(10);
    sda_drive <= 1'b0;
    tick(10);
  endtask : stop

  // Data set well inside the low phase so it never moves under a high clock
  task automatic bit_xfer(input logic b, output logic r);
    tick(3);
    sda_drive <= ~b;
    tick(7);
    scl <= 1'b1;
    tick(10);
    r = sda;
    scl <= 1'b0;
  endtask : bit_xfer

  // Byte out MSB first, acknowledge level back
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
    bit_xfer(1'b1, ack);
  endtask : send_byte

  // Byte in; the final byte is left unacknowledged
  task automatic recv_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
    bit_xfer(~more, r);
  endtask : recv_byte
endmodule : i2c_master_model

// >>> i2c_expander_transition_detect_tb_top.sv
// Self-checking bench for the transition-detecting port expander
`timescale 1ns/1ns
`include "expander_params.svh"
module i2c_expander_transition_detect_tb_top;
  import expander_pkg::*;
  localparam logic [6:0] IN_A  = {`IN_GROUP_PREFIX, 4'h0};
  localparam logic [6:0] OUT_A = {`OUT_GROUP_PREFIX, 4'h0};
  logic       clock, reset_n, enable, apply_ready, sda_oe, sda_out, alert_n;
  logic       scl, sda, sda_drive, addr_pin_high, addr_pin_low, alert_mid;
  port_byte_t input_pins, output_pins, v, w, u, chg_val;
  port_byte_t wbuf [34];
  port_byte_t rbuf [4];
  logic       ack_q [35];
  pin_kind_e  hi_k, lo_k;
  logic [6:0] a;
  int         err_count, n_tests, chg_at;

  // Pulled-up data wire; the device only ever pulls low
  assign sda           = !(sda_drive || (sda_oe && !sda_out));
  assign addr_pin_high = (hi_k == PIN_SCL) ? scl : (hi_k == PIN_SDA) ? sda : (hi_k == PIN_SUPPLY);
  assign addr_pin_low  = (lo_k == PIN_SCL) ? scl : (lo_k == PIN_SDA) ? sda : (lo_k == PIN_SUPPLY);

  port_expander u_dut (.clock(clock), .reset_n(reset_n), .enable(enable), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin_high(addr_pin_high),
    .addr_pin_low(addr_pin_low), .input_pins(input_pins), .output_pins(output_pins),
    .apply_ready(apply_ready), .alert_n(alert_n));
  i2c_master_model u_m (.clock(clock), .sda(sda), .scl(scl), .sda_drive(sda_drive));

  // 250 MHz system clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cyc

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic ck1(input logic got, input logic exp, input string what);
    check({7'h0, got}, {7'h0, exp}, what);
  endtask : ck1

  // One framed transfer; inputs may change just before byte chg_at
  task automatic xfer(input logic [6:0] ad, input logic rd, input int n);
    u_m.start();
    u_m.send_byte({ad, rd}, ack_q[0]);
    for (int i = 0; i < n; i++) begin
      if (i == chg_at) input_pins <= chg_val;
      if (rd) u_m.recv_byte(i < n - 1, rbuf[i]);
      else u_m.send_byte(wbuf[i], ack_q[i + 1]);
    end
    alert_mid = alert_n;
    u_m.stop();
  endtask : xfer

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Hang guard, well beyond the expected run of about 23k cycles
  initial begin
    wait_cyc(80000);
    err_count++;
    complete_run();
  end

  initial begin
    void'($urandom(15190));
    reset_n     = 1'b0;
    enable      = 1'b1;
    apply_ready = 1'b0;
    input_pins  = 8'h00;
    hi_k        = PIN_SCL;
    lo_k        = PIN_GND;
    chg_at      = -1;
    chg_val     = 8'h00;
    v           = 8'h00;
    wait_cyc(12);
    reset_n <= 1'b1;
    wait_cyc(10);
    check(output_pins, 8'hf0, "power-up outputs");
    // Random changes raise the alert, are reported and cleared
    repeat (4) begin
      w = port_byte_t'($urandom_range(1, 255));
      input_pins <= v ^ w;
      wait_cyc(10);
      ck1(alert_n, 1'b0, "alert on change");
      xfer(IN_A, 1'b1, 2);
      check(rbuf[0], v ^ w, "input byte");
      check(rbuf[1], w, "flag byte");
      v = v ^ w;
      ck1(alert_n, 1'b1, "alert cleared");
      xfer(IN_A, 1'b1, 2);
      check(rbuf[1], 8'h00, "flags cleared");
    end
    // Second mask byte wins; a masked transient still leaves its flag
    wbuf[0] = 8'hff;
    wbuf[1] = 8'h01;
    xfer(IN_A, 1'b0, 2);
    ck1(ack_q[2], 1'b0, "mask byte ack");
    input_pins <= v ^ 8'h02;
    wait_cyc(10);
    input_pins <= v;
    wait_cyc(10);
    ck1(alert_n, 1'b1, "masked change");
    xfer(IN_A, 1'b1, 2);
    check(rbuf[1], 8'h02, "transient flag");
    input_pins <= v ^ 8'h01;
    wait_cyc(10);
    ck1(alert_n, 1'b0, "unmasked change");
    v = v ^ 8'h01;
    // A change during a read holds the alert back until STOP
    wbuf[0] = 8'hff;
    xfer(IN_A, 1'b0, 1);
    u = port_byte_t'($urandom_range(1, 255));
    chg_val = v ^ u;
    chg_at = 0;
    xfer(IN_A, 1'b1, 1);
    ck1(alert_mid, 1'b1, "quiet during read");
    check(rbuf[0], v, "relatched input");
    wait_cyc(4);
    ck1(alert_n, 1'b0, "alert at stop");
    // Long read: fresh second pair means no alert at STOP
    v = v ^ u;
    w = port_byte_t'($urandom_range(1, 255));
    chg_val = v ^ w;
    chg_at = 1;
    xfer(IN_A, 1'b1, 4);
    check(rbuf[0], v, "pair one data");
    check(rbuf[1], u, "pair one flags");
    check(rbuf[2], v ^ w, "pair two data");
    check(rbuf[3], w, "pair two flags");
    wait_cyc(20);
    ck1(alert_n, 1'b1, "no repeat alert");
    v = v ^ w;
    chg_at = -1;
    // Output group written, read back; a foreign prefix is ignored
    apply_ready <= 1'b1;
    for (int i = 0; i < 3; i++) wbuf[i] = port_byte_t'($urandom);
    xfer(OUT_A, 1'b0, 3);
    wait_cyc(10);
    check(output_pins, wbuf[2], "outputs written");
    xfer(OUT_A, 1'b1, 2);
    check(rbuf[0], wbuf[2], "outputs read first");
    check(rbuf[1], wbuf[2], "outputs read");
    u = wbuf[2];
    xfer({3'h7, 4'h0}, 1'b0, 0);
    ck1(ack_q[0], 1'b1, "foreign prefix");
    // Fill the queue with the consumer stalled, then drain it
    apply_ready <= 1'b0;
    for (int i = 0; i < 33; i++) wbuf[i] = port_byte_t'($urandom);
    xfer(OUT_A, 1'b0, 33);
    check(output_pins, u, "stall");
    ck1(ack_q[32], 1'b0, "last queued byte");
    ck1(ack_q[33], 1'b1, "full queue refused");
    apply_ready <= 1'b1;
    wait_cyc(40);
    check(output_pins, wbuf[31], "queue drained");
    // Frozen block ignores a change until enable returns
    enable     <= 1'b0;
    input_pins <= v ^ 8'h80;
    wait_cyc(10);
    ck1(alert_n, 1'b1, "frozen alert");
    enable <= 1'b1;
    wait_cyc(10);
    ck1(alert_n, 1'b0, "alert after thaw");
    v = v ^ 8'h80;
    // Every pin pairing, decoded afresh on each transmission
    for (int i = 0; i < 16; i++) begin
      hi_k <= pin_kind_e'(i[3:2]);
      lo_k <= pin_kind_e'(i[1:0]);
      wait_cyc(1);
      a = {`IN_GROUP_PREFIX, i[3:2] ^ 2'h2, i[1:0]}; // High codes run SCL, SDA, GND, supply
      xfer(a, 1'b0, 0);
      ck1(ack_q[0], 1'b0, "own address");
      xfer(a ^ 7'h01, 1'b0, 0);
      ck1(ack_q[0], 1'b1, "neighbour address");
    end
    complete_run();
  end
endmodule : i2c_expander_transition_detect_tb_top
